// ---- rtl/icl_client.sv ----
// I2C client bus logic: conditions, address match, acknowledge, byte FIFO.
// Assumes SCL/SDA inputs are asynchronous pins; control ports are on clk.
`timescale 1ns/1ps
`default_nettype none

module icl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
        in_ready <= (count_reg != (AW + 1)'(DEPTH - 1));
        out_valid <= 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
        in_ready <= 1'b1;
        out_valid <= (count_reg != (AW + 1)'(1));
      end
    end
  end
endmodule

module icl_client
  import icl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus pins, open-drain: enable high pulls the line low
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Configuration
  input wire logic [3:0] port_mode_select,
  input wire logic start_irq_enable,
  input wire logic stop_irq_enable,
  input wire logic address_hold_enable,
  input wire logic data_hold_enable,
  input wire logic ack_value_select,
  input wire logic [7:0] address_mask_reg,
  // Software strobes
  input wire logic address_match_wr,
  input wire logic [7:0] address_match_wdata,
  input wire logic clock_release_set,
  input wire logic tx_load,
  input wire logic [7:0] tx_data,
  input wire logic port_event_clear,
  input wire logic overflow_clear,
  input wire logic collision_clear,
  // Received bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // Status
  output logic [7:0] address_match_reg,
  output logic [7:0] receive_buffer_reg,
  output logic bus_active_reg,
  output logic port_event_flag,
  output logic ack_received_flag,
  output logic ack_window_flag,
  output logic low_address_update_flag,
  output logic clock_release_bit,
  output logic buffer_full_flag,
  output logic receive_overflow_flag,
  output logic bus_collision_flag,
  output logic prior_match_flag,
  output logic read_request_reg
);
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic seen_low_reg;
  icl_state_t state_reg;
  icl_phase_t phase_reg;
  icl_hold_t hold_reg;
  icl_next_t next_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic tx_loaded_reg;
  logic low_ok_reg;
  logic ack_drive_reg;
  logic [7:0] byte_in;
  logic ten_bit, sp_mode, hold_en;
  logic match7, match_high, match_low, ack_ok, addr_hit;
  logic push_byte, fifo_ready, set_event, set_ovf;

  // Second stage feeds everything; first stage is read by it alone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  assign scl_rise = scl_sync_reg && !scl_prev_reg;
  assign scl_fall = !scl_sync_reg && scl_prev_reg;
  assign start_det = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
  assign stop_det = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg && seen_low_reg;

  assign ten_bit = (port_mode_select == ICL_MODE_10BIT) || (port_mode_select == ICL_MODE_10BIT_SP);
  assign sp_mode = (port_mode_select == ICL_MODE_7BIT_SP) || (port_mode_select == ICL_MODE_10BIT_SP);
  assign hold_en = address_hold_enable || data_hold_enable;
  assign byte_in = shift_reg;

  // Masked bits never take part in an address comparison; the 10-bit head 11110 is always compared
  assign match7 = (((byte_in ^ address_match_reg) & ~address_mask_reg) & 8'hfe) == 8'h00;
  assign match_high = (byte_in[7:3] == ICL_TEN_BIT_HEAD)
                      && (((byte_in[2:1] ^ address_match_reg[2:1]) & ~address_mask_reg[2:1]) == 2'h0);
  assign match_low = ((byte_in ^ address_match_reg) & ~address_mask_reg) == 8'h00;
  assign ack_ok = !(buffer_full_flag || receive_overflow_flag);
  assign addr_hit = (phase_reg != PH_ADDR) || (ten_bit ? (match_high && (!byte_in[0] || prior_match_flag)) : match7);

  // Seen-low qualifies a Stop; a Start with SCL held high cannot end itself
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen_low_reg <= 1'b0;
    end else if (start_det) begin
      seen_low_reg <= 1'b0;
    end else if (scl_fall) begin
      seen_low_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_active_reg <= 1'b0;
    end else if (start_det) begin
      bus_active_reg <= 1'b1;
    end else if (stop_det) begin
      bus_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      address_match_reg <= ICL_ADDR_RESET;
    end else if (address_match_wr) begin
      address_match_reg <= address_match_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_shift_reg <= 8'h00;
      tx_loaded_reg <= 1'b0;
    end else if (tx_load) begin
      tx_shift_reg <= tx_data;
      tx_loaded_reg <= 1'b1;
    end else if (state_reg == ST_SEND && scl_fall && bit_cnt_reg < ICL_BITS_PER_BYTE) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end else if (state_reg == ST_HOLD && hold_reg == HK_TX && clock_release_set) begin
      tx_loaded_reg <= 1'b0;
    end
  end

  // Main sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_ADDR;
      hold_reg <= HK_ACK;
      next_reg <= NA_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      low_ok_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      ack_window_flag <= 1'b0;
      low_address_update_flag <= 1'b0;
      clock_release_bit <= 1'b1;
      prior_match_flag <= 1'b0;
      read_request_reg <= 1'b0;
      ack_received_flag <= 1'b0;
      push_byte <= 1'b0;
    end else begin
      push_byte <= 1'b0;
      if (address_match_wr) begin
        low_address_update_flag <= 1'b0;
      end
      if (start_det) begin
        state_reg <= ST_RECV;
        phase_reg <= PH_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
        ack_window_flag <= 1'b0;
        read_request_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
        ack_window_flag <= 1'b0;
        prior_match_flag <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
          end
          ST_RECV: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == ICL_BITS_PER_BYTE) begin
              next_reg <= NA_RECV;
              ack_drive_reg <= ack_ok;
              if (phase_reg == PH_ADDR && !ten_bit) begin
                if (!match7) begin
                  state_reg <= ST_IDLE;
                end else begin
                  push_byte <= 1'b1;
                  read_request_reg <= byte_in[0];
                  if (byte_in[0]) begin
                    next_reg <= NA_TX;
                  end
                end
              end else if (phase_reg == PH_ADDR) begin
                if (!match_high) begin
                  prior_match_flag <= 1'b0;
                  state_reg <= ST_IDLE;
                end else if (!byte_in[0]) begin
                  prior_match_flag <= 1'b0;
                  push_byte <= 1'b1;
                  next_reg <= NA_UA;
                end else if (prior_match_flag) begin
                  push_byte <= 1'b1;
                  read_request_reg <= 1'b1;
                  next_reg <= NA_TX;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (phase_reg == PH_LOW) begin
                low_ok_reg <= match_low;
                ack_drive_reg <= match_low;
                next_reg <= NA_UA;
                push_byte <= match_low;
              end else begin
                push_byte <= 1'b1;
              end
              if (addr_hit && hold_en) begin
                ack_window_flag <= 1'b1;
                scl_oe <= 1'b1;
                clock_release_bit <= 1'b0;
                hold_reg <= HK_ACK;
                state_reg <= ST_HOLD;
              end else if (addr_hit) begin
                state_reg <= ST_ACK;
                sda_oe <= (phase_reg == PH_LOW) ? match_low : ack_ok;
              end
            end
          end
          ST_HOLD: begin
            unique case (hold_reg)
              HK_ACK: begin
                if (clock_release_set) begin
                  clock_release_bit <= 1'b1;
                  scl_oe <= 1'b0;
                  sda_oe <= !ack_value_select;
                  ack_drive_reg <= !ack_value_select;
                  state_reg <= ST_ACK;
                end
              end
              HK_UA: begin
                if (address_match_wr) begin
                  scl_oe <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  if (phase_reg == PH_ADDR) begin
                    phase_reg <= PH_LOW;
                    state_reg <= ST_RECV;
                  end else if (low_ok_reg) begin
                    prior_match_flag <= 1'b1;
                    phase_reg <= PH_DATA;
                    state_reg <= ST_RECV;
                  end else begin
                    state_reg <= ST_IDLE;
                  end
                end
              end
              HK_TX: begin
                if (clock_release_set && tx_loaded_reg) begin
                  clock_release_bit <= 1'b1;
                  scl_oe <= 1'b0;
                  sda_oe <= !tx_shift_reg[7];
                  bit_cnt_reg <= 4'h0;
                  state_reg <= ST_SEND;
                end
              end
              default: state_reg <= ST_IDLE;
            endcase
          end
          ST_ACK: begin
            if (scl_rise) begin
              ack_window_flag <= 1'b0;
              bit_cnt_reg <= ICL_ACK_BIT;
            end else if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_cnt_reg <= 4'h0;
              if (!ack_drive_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                unique case (next_reg)
                  NA_RECV: begin
                    state_reg <= ST_RECV;
                    if (phase_reg == PH_ADDR) begin
                      phase_reg <= PH_DATA;
                    end
                  end
                  NA_UA: hold_reg <= HK_UA;
                  NA_TX: begin
                    clock_release_bit <= 1'b0;
                    scl_oe <= 1'b1;
                    hold_reg <= HK_TX;
                    state_reg <= ST_HOLD;
                  end
                  NA_IDLE: state_reg <= ST_IDLE;
                endcase
              end
              if (next_reg == NA_UA) begin
                low_address_update_flag <= 1'b1;
                scl_oe <= 1'b1;
                hold_reg <= HK_UA;
                state_reg <= ST_HOLD;
              end
            end
          end
          ST_SEND: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (!sda_oe && !sda_sync_reg) begin
                state_reg <= ST_IDLE;
              end
            end else if (scl_fall) begin
              if (bit_cnt_reg < ICL_BITS_PER_BYTE) begin
                sda_oe <= !tx_shift_reg[6];
              end else begin
                sda_oe <= 1'b0;
                state_reg <= ST_ASKACK;
              end
            end
          end
          ST_ASKACK: begin
            if (scl_rise) begin
              ack_received_flag <= sda_sync_reg;
              if (sda_sync_reg) begin
                state_reg <= ST_IDLE;
              end
            end else if (scl_fall) begin
              clock_release_bit <= 1'b0;
              scl_oe <= 1'b1;
              hold_reg <= HK_TX;
              state_reg <= ST_HOLD;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Events: Start/Stop per mode, address and data bytes at their ack points
  always_comb begin
    set_event = 1'b0;
    if (start_det && (sp_mode || start_irq_enable)) begin
      set_event = 1'b1;
    end
    if (stop_det && (sp_mode || stop_irq_enable)) begin
      set_event = 1'b1;
    end
    if (push_byte) begin
      set_event = 1'b1;
    end
    if (state_reg == ST_ACK && scl_fall && next_reg == NA_UA && phase_reg == PH_LOW) begin
      set_event = 1'b1;
    end
    if (state_reg == ST_ASKACK && scl_fall) begin
      set_event = 1'b1;
    end
  end

  assign set_ovf = push_byte && !fifo_ready;

  // Set wins over a simultaneous clear on every sticky flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_event_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
      bus_collision_flag <= 1'b0;
    end else begin
      port_event_flag <= set_event || (port_event_flag && !port_event_clear);
      receive_overflow_flag <= set_ovf || (receive_overflow_flag && !overflow_clear);
      bus_collision_flag <= (state_reg == ST_SEND && scl_rise && !sda_oe && !sda_sync_reg)
                            || (bus_collision_flag && !collision_clear);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      receive_buffer_reg <= 8'h00;
      buffer_full_flag <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      if (push_byte && fifo_ready) begin
        receive_buffer_reg <= byte_in;
      end
      buffer_full_flag <= !fifo_ready;
    end
  end

  icl_fifo #(
    .WIDTH(ICL_FIFO_WIDTH),
    .DEPTH(ICL_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push_byte),
    .in_ready(fifo_ready),
    .in_data(byte_in),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );
endmodule

`default_nettype wire

// ---- rtl/icl_pkg.sv ----
// Shared constants for the I2C client address and acknowledge logic.
// Assumes one system clock; bus pins are open-drain and resolved outside.
// Overview of operation
// - Host makes Start; SDA falls, SCL high
// - Flag collision when SDA low unexpectedly
// - Stop is SDA rising while SCL high
// - Stop needs one SCL low after Start
// - Restart acts exactly like Start, resets state
// - 10-bit read after prior match stretches, transmits
// - Prior-match flag kept until Stop, mismatch or a matching 10-bit write high byte
// - Start/stop enables add events in plain modes
// - Ninth pulse: receiver pulls SDA low
// - Sampled host acknowledge stored in flag
// - Hold enables use software-chosen acknowledge value
// - Auto acknowledge unless buffer full or overflow; 10-bit low byte acks on match alone
// - Ack window flag after eighth falling edge when a hold is enabled
// - Four client modes selected by mode port
// - Event-interrupt modes flag Start, Restart, Stop
// - First byte compared; match loads buffer, event
// - 7-bit compare ignores read/write bit
// - 10-bit high byte is 11110 A9 A8 0
// - After high byte ack, update flag, stretch
// - Low byte compared fully; always flag, stretch
// - Address write clears low update flag
// - Ack window clears on ninth rising edge
// - Read address ack clears release bit, stretches
package icl_pkg;
  localparam logic [3:0] ICL_MODE_7BIT = 4'h6;
  localparam logic [3:0] ICL_MODE_10BIT = 4'h7;
  localparam logic [3:0] ICL_MODE_7BIT_SP = 4'he;
  localparam logic [3:0] ICL_MODE_10BIT_SP = 4'hf;
  localparam logic [4:0] ICL_TEN_BIT_HEAD = 5'h1e;
  localparam logic [3:0] ICL_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ICL_ACK_BIT = 4'h9;
  localparam logic [7:0] ICL_ADDR_RESET = 8'h00;
  localparam int ICL_FIFO_WIDTH = 8;
  localparam int ICL_FIFO_DEPTH = 32;

  typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_HOLD, ST_SEND, ST_ASKACK} icl_state_t;
  typedef enum logic [1:0] {PH_ADDR, PH_LOW, PH_DATA} icl_phase_t;
  typedef enum logic [1:0] {HK_ACK, HK_UA, HK_TX} icl_hold_t;
  typedef enum logic [1:0] {NA_RECV, NA_UA, NA_TX, NA_IDLE} icl_next_t;
endpackage

// ---- tb/icl_monitor.sv ----
// Concurrent checks on the client's pins and status ports.
// Assumes a single clock domain; bound to every client instance.
`timescale 1ns/1ps
`default_nettype none

module icl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Controls
  input wire logic address_hold_enable,
  input wire logic data_hold_enable,
  input wire logic ack_value_select,
  input wire logic address_match_wr,
  input wire logic clock_release_set,
  // Status
  input wire logic bus_active_reg,
  input wire logic ack_window_flag,
  input wire logic low_address_update_flag,
  input wire logic clock_release_bit,
  input wire logic buffer_full_flag,
  input wire logic receive_overflow_flag,
  input wire logic prior_match_flag,
  input wire logic read_request_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  wire logic hold_on = address_hold_enable || data_hold_enable;

  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_sw_release;
    ack_window_flag && clock_release_set;
  endsequence

  // Pin path is two sync flops plus the edge flop
  property p_start_seen;
    s_start |-> ##[2:6] bus_active_reg;
  endproperty
  property p_ua_clear;
    address_match_wr |=> !low_address_update_flag;
  endproperty
  property p_ua_stretch;
    low_address_update_flag |-> ##[0:1] scl_oe;
  endproperty
  property p_window_hold;
    ack_window_flag |-> hold_on;
  endproperty
  property p_window_end;
    ack_window_flag && $rose(scl_in) |-> ##[1:6] !ack_window_flag;
  endproperty
  property p_sw_ack;
    s_sw_release |=> ##[0:1] (sda_oe == !ack_value_select);
  endproperty
  property p_release;
    clock_release_set |=> clock_release_bit;
  endproperty
  property p_nack_full;
    $rose(sda_oe) && !hold_on && !read_request_reg |-> !$past(buffer_full_flag) && !$past(receive_overflow_flag);
  endproperty
  property p_prior_stop;
    $fell(bus_active_reg) |-> ##[0:1] !prior_match_flag;
  endproperty

  a_start_seen: assert property (p_start_seen) else $error("start not seen");
  a_ua_clear: assert property (p_ua_clear) else $error("update flag kept");
  a_ua_stretch: assert property (p_ua_stretch) else $error("no stretch on update");
  a_window_hold: assert property (p_window_hold) else $error("ack window without hold");
  a_window_end: assert property (p_window_end) else $error("ack window not ended");
  a_sw_ack: assert property (p_sw_ack) else $error("wrong chosen ack");
  a_release: assert property (p_release) else $error("release bit not set");
  a_nack_full: assert property (p_nack_full) else $error("ack while full");
  a_prior_stop: assert property (p_prior_stop) else $error("prior match kept");
endmodule

bind icl_client icl_monitor mon_u (
  .clk, .sys_rst, .scl_in, .sda_in, .scl_oe, .sda_oe, .address_hold_enable, .data_hold_enable,
  .ack_value_select, .address_match_wr, .clock_release_set, .bus_active_reg, .ack_window_flag,
  .low_address_update_flag, .clock_release_bit, .buffer_full_flag, .receive_overflow_flag,
  .prior_match_flag, .read_request_reg
);
`default_nettype wire

// ---- tb/icl_host_model.sv ----
// Behavioural I2C host: drives open-drain SCL/SDA, 210 ns bit time.
// Assumes the bench resolves the wired lines and feeds them back.
`timescale 1ns/1ps
`default_nettype none

module icl_host_model (
  // Clock
  input wire logic clk,
  // Resolved lines
  input wire logic scl_line,
  input wire logic sda_line,
  // Drive levels, high means released
  output logic scl_drv,
  output logic sda_drv
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic half();
    repeat (8) @(posedge clk);
  endtask

  // The client may stretch; a bounded wait keeps a stuck bus from hanging
  task automatic rise();
    int n;
    n = 0;
    scl_drv <= 1'b1;
    @(posedge clk);
    while (!scl_line && n < 4000) begin
      @(posedge clk);
      n++;
    end
    half();
  endtask

  task automatic start_cond();
    @(posedge clk);
    sda_drv <= 1'b1;
    half();
    rise();
    sda_drv <= 1'b0;
    half();
    scl_drv <= 1'b0;
    half();
  endtask

  task automatic stop_cond();
    @(posedge clk);
    sda_drv <= 1'b0;
    half();
    rise();
    sda_drv <= 1'b1;
    half();
  endtask

  // SDA low and high again with SCL never low
  task automatic glitch();
    @(posedge clk);
    sda_drv <= 1'b0;
    half();
    sda_drv <= 1'b1;
    half();
  endtask

  // Data moves only after the client has seen SCL low
  task automatic bit_x(input logic b, output logic r);
    @(posedge clk);
    sda_drv <= b;
    half();
    rise();
    r = sda_line;
    scl_drv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the I2C client address and acknowledge logic.
// Assumes the host model on the bus and pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import icl_pkg::*;
  logic clk;
  logic sys_rst = 1'b1, rx_ready = 1'b0, start_irq_enable = 1'b0, stop_irq_enable = 1'b0;
  logic address_hold_enable = 1'b0, data_hold_enable = 1'b0, ack_value_select = 1'b0;
  logic [3:0] port_mode_select = ICL_MODE_7BIT;
  logic [7:0] address_mask_reg = 8'h00, wdata = 8'h00, tx_data = 8'h00, q;
  logic [5:0] stb = 6'h00;
  logic scl_h, sda_h, a, scl_oe, sda_oe, rx_valid, bus_active_reg, port_event_flag;
  logic ack_received_flag, ack_window_flag, low_address_update_flag, clock_release_bit;
  logic buffer_full_flag, receive_overflow_flag, prior_match_flag, read_request_reg, bus_collision_flag;
  logic [7:0] rx_data, address_match_reg, receive_buffer_reg;
  int miscompares = 0;
  int n_tests = 0;
  wire logic scl_in = scl_h & ~scl_oe;
  wire logic sda_in = sda_h & ~sda_oe;

  icl_client dut_u (
    .clk, .sys_rst, .scl_in, .scl_out(), .scl_oe, .sda_in, .sda_out(), .sda_oe, .port_mode_select,
    .start_irq_enable, .stop_irq_enable, .address_hold_enable, .data_hold_enable, .ack_value_select,
    .address_mask_reg, .address_match_wr(stb[0]), .address_match_wdata(wdata), .clock_release_set(stb[1]),
    .tx_load(stb[2]), .tx_data, .port_event_clear(stb[3]), .overflow_clear(stb[4]), .collision_clear(stb[5]),
    .rx_valid, .rx_ready, .rx_data, .address_match_reg, .receive_buffer_reg, .bus_active_reg,
    .port_event_flag, .ack_received_flag, .ack_window_flag, .low_address_update_flag, .clock_release_bit,
    .buffer_full_flag, .receive_overflow_flag, .bus_collision_flag, .prior_match_flag, .read_request_reg
  );
  icl_host_model host_u (.clk, .scl_line(scl_in), .sda_line(sda_in), .scl_drv(scl_h), .sda_drv(sda_h));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chb(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask

  // Flags land a few cycles after the pin edge
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic strobe(input int k, input logic [7:0] v);
    @(posedge clk);
    wdata <= v;
    tx_data <= v;
    stb[k] <= 1'b1;
    @(posedge clk);
    stb <= 6'h00;
  endtask

  task automatic wbyte(input logic [7:0] d, input logic exp_ack);
    host_u.xfer(d, q);
    host_u.bit_x(1'b1, a);
    chb(a, exp_ack);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The sequence needs about 8.5k cycles; allow nearly six times that
  initial begin
    #500000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    chk(address_match_reg, ICL_ADDR_RESET);
    chb(clock_release_bit, 1'b1);
    strobe(0, 8'h54);
    host_u.start_cond();
    settle();
    chb(bus_active_reg, 1'b1);
    wbyte(8'h54, 1'b0);
    settle();
    chk(receive_buffer_reg, 8'h54);
    chb(port_event_flag, 1'b1);
    for (int i = 1; i < 32; i++) begin
      wbyte(8'(i), 1'b0);
    end
    wbyte(8'hee, 1'b1);
    settle();
    chb(buffer_full_flag, 1'b1);
    chb(receive_overflow_flag, 1'b1);
    host_u.stop_cond();
    settle();
    chb(bus_active_reg, 1'b0);
    @(posedge clk);
    rx_ready <= 1'b1;
    for (int k = 0; k < 32; k++) begin
      @(negedge clk);
      chk(rx_data, (k == 0) ? 8'h54 : 8'(k));
      @(posedge clk);
    end
    rx_ready <= 1'b0;
    settle();
    chb(rx_valid, 1'b0);
    strobe(4, 8'h00);
    strobe(3, 8'h00);
    host_u.start_cond();
    wbyte(8'h56, 1'b1);
    settle();
    chb(port_event_flag, 1'b0);
    @(posedge clk);
    address_mask_reg <= 8'h02;
    host_u.start_cond();
    wbyte(8'h56, 1'b0);
    host_u.stop_cond();
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      address_mask_reg <= 8'h00;
      address_hold_enable <= 1'b1;
      ack_value_select <= v[0];
      host_u.start_cond();
      host_u.xfer(8'h54, q);
      settle();
      chb(ack_window_flag, 1'b1);
      chb(scl_oe, 1'b1);
      strobe(1, 8'h00);
      host_u.bit_x(1'b1, a);
      chb(a, v[0]);
      settle();
      chb(ack_window_flag, 1'b0);
      host_u.stop_cond();
    end
    address_hold_enable <= 1'b0;
    port_mode_select <= ICL_MODE_7BIT_SP;
    strobe(3, 8'h00);
    host_u.glitch();
    settle();
    chb(bus_active_reg, 1'b1);
    chb(port_event_flag, 1'b1);
    host_u.start_cond();
    host_u.stop_cond();
    settle();
    chb(bus_active_reg, 1'b0);
    @(posedge clk);
    port_mode_select <= ICL_MODE_7BIT;
    start_irq_enable <= 1'b1;
    stop_irq_enable <= 1'b1;
    strobe(3, 8'h00);
    host_u.start_cond();
    settle();
    chb(port_event_flag, 1'b1);
    strobe(3, 8'h00);
    host_u.stop_cond();
    settle();
    chb(port_event_flag, 1'b1);
    @(posedge clk);
    start_irq_enable <= 1'b0;
    port_mode_select <= ICL_MODE_10BIT;
    strobe(0, 8'hf4);
    host_u.start_cond();
    wbyte(8'hf4, 1'b0);
    settle();
    chb(low_address_update_flag, 1'b1);
    chb(scl_oe, 1'b1);
    strobe(0, 8'hc5);
    settle();
    chb(low_address_update_flag, 1'b0);
    wbyte(8'hc5, 1'b0);
    settle();
    chb(low_address_update_flag, 1'b1);
    strobe(0, 8'hf4);
    settle();
    chb(prior_match_flag, 1'b1);
    host_u.start_cond();
    wbyte(8'hf5, 1'b0);
    settle();
    chb(clock_release_bit, 1'b0);
    chb(read_request_reg, 1'b1);
    strobe(2, 8'h3c);
    strobe(1, 8'h00);
    host_u.xfer(8'hff, q);
    host_u.bit_x(1'b1, a);
    chk(q, 8'h3c);
    settle();
    chb(ack_received_flag, 1'b1);
    host_u.stop_cond();
    settle();
    chb(prior_match_flag, 1'b0);
    chb(bus_collision_flag, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
